// file: serial_vc_consts.svh
`ifndef SERIAL_VC_CONSTS_SVH
`define SERIAL_VC_CONSTS_SVH

// ----------------------------------------------------------------
// bus geometry and answers
// ----------------------------------------------------------------
`define AXI_ADDR_W          12
`define AXI_DATA_W          32
`define RESP_OKAY           2'h0
`define RESP_SLVERR         2'h2

// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define OFS_SERIAL_LOWER    12'h184
`define OFS_SERIAL_UPPER    12'h188
`define OFS_VC_CAP_HEADER   12'h200
`define OFS_PORT_VC_CAP_ONE 12'h204
`define OFS_PORT_VC_CAP_TWO 12'h208

// ----------------------------------------------------------------
// reset values and fixed field values
// ----------------------------------------------------------------
`define SERIAL_RESET        32'h0
`define NEXT_PTR_RESET      12'h000
`define NEXT_PTR_LSB        20
`define CAP_ID_VC           16'h0002
`define CAP_VERSION         4'h1
`define EXT_CH_COUNT        3'h1
`define LOW_PRIO_COUNT      3'h0
`define ARB_TIME_REF        2'h0
`define PORT_ARB_ENTRY_SIZE 2'h2
`define CH_ARB_CAP          8'h00
`define CH_ARB_TABLE_OFS    8'h00

`endif

// file: serial_vc_pkg.sv
package serial_vc_pkg;

	// ----------------------------------------------------------------
	// register select, one-hot
	// ----------------------------------------------------------------
	typedef enum logic [5:0]
	{
		SEL_NONE   = 6'b000001,
		SEL_SER_LO = 6'b000010,
		SEL_SER_HI = 6'b000100,
		SEL_VC_HDR = 6'b001000,
		SEL_VC_CP1 = 6'b010000,
		SEL_VC_CP2 = 6'b100000
	} reg_sel_t;

	// ----------------------------------------------------------------
	// channel state machines
	// ----------------------------------------------------------------
	typedef enum logic [1:0]
	{
		WR_COLLECT = 2'b01,
		WR_RESP    = 2'b10
	} wr_state_t;

	typedef enum logic [1:0]
	{
		RD_IDLE = 2'b01,
		RD_RESP = 2'b10
	} rd_state_t;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed
	{
		logic [11:0] addr;
		logic [31:0] data;
		logic [3:0]  strb;
	} wr_req_t;

	typedef struct packed
	{
		logic [31:0] data;
		logic [1:0]  resp;
	} rd_word_t;

endpackage : serial_vc_pkg

// file: sticky_unlockable_reg.sv
`timescale 1ns/1ns

module sticky_unlockable_reg
#(
	parameter int               WIDTH       = 32,
	parameter logic [WIDTH-1:0] RESET_VALUE = '0
)
(
	// clock, cold reset, enable
	input  wire logic             clk_sys_i,
	input  wire logic             cold_reset_i,
	input  wire logic             ce_i,
	// write request
	input  wire logic             write_i,
	input  wire logic             locked_i,
	input  wire logic [WIDTH-1:0] mask_i,
	input  wire logic [WIDTH-1:0] data_i,
	// stored value
	output logic      [WIDTH-1:0] value_o
);

	// sticky: only the cold reset clears it, the bus reset leaves it
	always_ff @(posedge clk_sys_i or posedge cold_reset_i)
	begin
		if (cold_reset_i)
			value_o <= RESET_VALUE;
		else if (ce_i && write_i && !locked_i)
			value_o <= (value_o & ~mask_i) | (data_i & mask_i);
	end

endmodule : sticky_unlockable_reg

// file: serial_vc_cap_regs.sv
// Implementation choice: the AXI4-Lite interface to the registers.

`timescale 1ns/1ns
`include "serial_vc_consts.svh"

module serial_vc_cap_regs
(
	// clock, resets, enable
	input  wire logic                   clk_sys_i,
	input  wire logic                   reset_i,
	input  wire logic                   cold_reset_i,
	input  wire logic                   ce_i,
	// field lock
	input  wire logic                   fields_locked_i,
	// write address channel
	input  wire logic [`AXI_ADDR_W-1:0] s_axi_awaddr_i,
	input  wire logic                   s_axi_awvalid_i,
	output logic                        s_axi_awready_o,
	// write data channel
	input  wire logic [`AXI_DATA_W-1:0] s_axi_wdata_i,
	input  wire logic [3:0]             s_axi_wstrb_i,
	input  wire logic                   s_axi_wvalid_i,
	output logic                        s_axi_wready_o,
	// write response channel
	output logic      [1:0]             s_axi_bresp_o,
	output logic                        s_axi_bvalid_o,
	input  wire logic                   s_axi_bready_i,
	// read address channel
	input  wire logic [`AXI_ADDR_W-1:0] s_axi_araddr_i,
	input  wire logic                   s_axi_arvalid_i,
	output logic                        s_axi_arready_o,
	// read data channel
	output logic      [`AXI_DATA_W-1:0] s_axi_rdata_o,
	output logic      [1:0]             s_axi_rresp_o,
	output logic                        s_axi_rvalid_o,
	input  wire logic                   s_axi_rready_i,
	// stored values for the rest of the port
	output logic      [63:0]            serial_value_o,
	output logic      [11:0]            next_capability_pointer_o
);

	// ----------------------------------------------------------------
	// functions
	// ----------------------------------------------------------------
	function automatic serial_vc_pkg::reg_sel_t decode_sel
	(
		input logic [`AXI_ADDR_W-1:0] addr
	);
		logic [`AXI_ADDR_W-1:0] word;
		word = {addr[`AXI_ADDR_W-1:2], 2'b00};
		if (word == `OFS_SERIAL_LOWER)
			decode_sel = serial_vc_pkg::SEL_SER_LO;
		else if (word == `OFS_SERIAL_UPPER)
			decode_sel = serial_vc_pkg::SEL_SER_HI;
		else if (word == `OFS_VC_CAP_HEADER)
			decode_sel = serial_vc_pkg::SEL_VC_HDR;
		else if (word == `OFS_PORT_VC_CAP_ONE)
			decode_sel = serial_vc_pkg::SEL_VC_CP1;
		else if (word == `OFS_PORT_VC_CAP_TWO)
			decode_sel = serial_vc_pkg::SEL_VC_CP2;
		else
			decode_sel = serial_vc_pkg::SEL_NONE;
	endfunction : decode_sel

	function automatic logic [31:0] strobe_mask
	(
		input logic [3:0] strb
	);
		strobe_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
	endfunction : strobe_mask

	function automatic serial_vc_pkg::rd_word_t read_word
	(
		input serial_vc_pkg::reg_sel_t sel,
		input logic [31:0]             lo,
		input logic [31:0]             hi,
		input logic [11:0]             nptr
	);
		read_word.resp = `RESP_OKAY;
		if (sel == serial_vc_pkg::SEL_SER_LO)
			read_word.data = lo;
		else if (sel == serial_vc_pkg::SEL_SER_HI)
			read_word.data = hi;
		else if (sel == serial_vc_pkg::SEL_VC_HDR)
			read_word.data = {nptr, `CAP_VERSION, `CAP_ID_VC};
		else if (sel == serial_vc_pkg::SEL_VC_CP1)
			read_word.data = {20'h00000, `PORT_ARB_ENTRY_SIZE,
				`ARB_TIME_REF, 1'b0, `LOW_PRIO_COUNT,
				1'b0, `EXT_CH_COUNT};
		else if (sel == serial_vc_pkg::SEL_VC_CP2)
			read_word.data = {`CH_ARB_TABLE_OFS, 16'h0000,
				`CH_ARB_CAP};
		else
		begin
			read_word.data = 32'h00000000;
			read_word.resp = `RESP_SLVERR;
		end
	endfunction : read_word

	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	serial_vc_pkg::wr_state_t wr_state;
	serial_vc_pkg::rd_state_t rd_state;
	serial_vc_pkg::wr_req_t   wr_req;
	serial_vc_pkg::reg_sel_t  wr_sel;
	serial_vc_pkg::reg_sel_t  rd_sel;
	serial_vc_pkg::rd_word_t  next_rd_word;
	logic                     commit;
	logic                     b_done;
	logic                     aw_take;
	logic                     w_take;
	logic                     ar_take;
	logic [31:0]              wr_mask;
	logic [31:0]              serial_lo;
	logic [31:0]              serial_hi;
	logic [11:0]              next_ptr;

	assign aw_take = ce_i && s_axi_awvalid_i && s_axi_awready_o;
	assign w_take  = ce_i && s_axi_wvalid_i && s_axi_wready_o;
	assign ar_take = ce_i && s_axi_arvalid_i && s_axi_arready_o;
	assign b_done  = ce_i && s_axi_bvalid_o && s_axi_bready_i;
	// both halves held: perform the write, the response follows next edge
	assign commit  = ce_i && (wr_state == serial_vc_pkg::WR_COLLECT)
		&& !s_axi_awready_o && !s_axi_wready_o;
	assign wr_sel  = decode_sel(wr_req.addr);
	assign wr_mask = strobe_mask(wr_req.strb);
	assign next_rd_word = read_word(decode_sel(s_axi_araddr_i),
		serial_lo, serial_hi, next_ptr);

	// ----------------------------------------------------------------
	// write address and data, taken in either order
	// ----------------------------------------------------------------
	// one process owns the whole request word, so it has a single driver
	always_ff @(posedge clk_sys_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			s_axi_awready_o <= 1'b1;
			s_axi_wready_o  <= 1'b1;
			wr_req          <= '0;
		end
		else
		begin
			if (aw_take)
			begin
				s_axi_awready_o <= 1'b0;
				wr_req.addr     <= s_axi_awaddr_i;
			end
			else if (b_done)
				s_axi_awready_o <= 1'b1;
			if (w_take)
			begin
				s_axi_wready_o <= 1'b0;
				wr_req.data    <= s_axi_wdata_i;
				wr_req.strb    <= s_axi_wstrb_i;
			end
			else if (b_done)
				s_axi_wready_o <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// write response
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			wr_state       <= serial_vc_pkg::WR_COLLECT;
			s_axi_bvalid_o <= 1'b0;
			s_axi_bresp_o  <= `RESP_OKAY;
		end
		else if (ce_i)
		begin
			case (wr_state)
				serial_vc_pkg::WR_COLLECT:
					if (commit)
					begin
						wr_state       <= serial_vc_pkg::WR_RESP;
						s_axi_bvalid_o <= 1'b1;
						// read-only targets answer okay and keep their value
						s_axi_bresp_o  <= (wr_sel == serial_vc_pkg::SEL_NONE)
							? `RESP_SLVERR : `RESP_OKAY;
					end
				serial_vc_pkg::WR_RESP:
					if (s_axi_bready_i)
					begin
						wr_state       <= serial_vc_pkg::WR_COLLECT;
						s_axi_bvalid_o <= 1'b0;
					end
				default:
				begin
					wr_state       <= serial_vc_pkg::WR_COLLECT;
					s_axi_bvalid_o <= 1'b0;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// read channel
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			rd_state        <= serial_vc_pkg::RD_IDLE;
			s_axi_arready_o <= 1'b1;
			s_axi_rvalid_o  <= 1'b0;
			s_axi_rdata_o   <= 32'h00000000;
			s_axi_rresp_o   <= `RESP_OKAY;
			rd_sel          <= serial_vc_pkg::SEL_NONE;
		end
		else if (ce_i)
		begin
			case (rd_state)
				serial_vc_pkg::RD_IDLE:
					if (ar_take)
					begin
						rd_state        <= serial_vc_pkg::RD_RESP;
						s_axi_arready_o <= 1'b0;
						s_axi_rvalid_o  <= 1'b1;
						s_axi_rdata_o   <= next_rd_word.data;
						s_axi_rresp_o   <= next_rd_word.resp;
						rd_sel          <= decode_sel(s_axi_araddr_i);
					end
				serial_vc_pkg::RD_RESP:
					if (s_axi_rready_i)
					begin
						rd_state        <= serial_vc_pkg::RD_IDLE;
						s_axi_arready_o <= 1'b1;
						s_axi_rvalid_o  <= 1'b0;
					end
				default:
				begin
					rd_state        <= serial_vc_pkg::RD_IDLE;
					s_axi_arready_o <= 1'b1;
					s_axi_rvalid_o  <= 1'b0;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// sticky, lockable storage
	// ----------------------------------------------------------------
	// the lock gates all three fields alike; it is held outside this block
	sticky_unlockable_reg
	#(
		.WIDTH       (32),
		.RESET_VALUE (`SERIAL_RESET)
	)
	u_serial_lo
	(
		.clk_sys_i    (clk_sys_i),
		.cold_reset_i (cold_reset_i),
		.ce_i         (ce_i),
		.write_i      (commit && wr_sel == serial_vc_pkg::SEL_SER_LO),
		.locked_i     (fields_locked_i),
		.mask_i       (wr_mask),
		.data_i       (wr_req.data),
		.value_o      (serial_lo)
	);

	sticky_unlockable_reg
	#(
		.WIDTH       (32),
		.RESET_VALUE (`SERIAL_RESET)
	)
	u_serial_hi
	(
		.clk_sys_i    (clk_sys_i),
		.cold_reset_i (cold_reset_i),
		.ce_i         (ce_i),
		.write_i      (commit && wr_sel == serial_vc_pkg::SEL_SER_HI),
		.locked_i     (fields_locked_i),
		.mask_i       (wr_mask),
		.data_i       (wr_req.data),
		.value_o      (serial_hi)
	);

	sticky_unlockable_reg
	#(
		.WIDTH       (12),
		.RESET_VALUE (`NEXT_PTR_RESET)
	)
	u_next_ptr
	(
		.clk_sys_i    (clk_sys_i),
		.cold_reset_i (cold_reset_i),
		.ce_i         (ce_i),
		.write_i      (commit && wr_sel == serial_vc_pkg::SEL_VC_HDR),
		.locked_i     (fields_locked_i),
		.mask_i       (wr_mask[31:`NEXT_PTR_LSB]),
		.data_i       (wr_req.data[31:`NEXT_PTR_LSB]),
		.value_o      (next_ptr)
	);

	assign serial_value_o            = {serial_hi, serial_lo};
	assign next_capability_pointer_o = next_ptr;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	sequence s_read_taken(serial_vc_pkg::reg_sel_t sel);
		ar_take && decode_sel(s_axi_araddr_i) == sel;
	endsequence

	sequence s_write_done(serial_vc_pkg::reg_sel_t sel);
		commit && wr_sel == sel && !fields_locked_i;
	endsequence

	property p_read_shows(serial_vc_pkg::reg_sel_t sel, logic [31:0] v);
		@(posedge clk_sys_i) disable iff (reset_i || cold_reset_i)
		s_read_taken(sel) |=> s_axi_rvalid_o && s_axi_rdata_o == $past(v);
	endproperty

	property p_field_fixed(serial_vc_pkg::reg_sel_t sel, logic ok);
		@(posedge clk_sys_i) disable iff (reset_i)
		s_axi_rvalid_o && rd_sel == sel |-> ok;
	endproperty

	a_serial_upper_read: assert property (
		p_read_shows(serial_vc_pkg::SEL_SER_HI, serial_hi))
		else $error("upper serial word read mismatch");

	a_serial_lower_read: assert property (
		p_read_shows(serial_vc_pkg::SEL_SER_LO, serial_lo))
		else $error("lower serial word read mismatch");

	a_serial_lock_hold: assert property (
		@(posedge clk_sys_i) disable iff (reset_i || cold_reset_i)
		fields_locked_i |=> $stable(serial_hi) && $stable(serial_lo)
			&& $stable(next_ptr))
		else $error("locked field changed");

	a_next_ptr_write: assert property (
		@(posedge clk_sys_i) disable iff (reset_i || cold_reset_i)
		s_write_done(serial_vc_pkg::SEL_VC_HDR) ##0 wr_req.strb[3:2] == 2'b11
		|=> next_ptr == $past(wr_req.data[31:`NEXT_PTR_LSB])
			&& s_axi_bvalid_o)
		else $error("next pointer not written");

	a_cap_identifier: assert property (
		p_field_fixed(serial_vc_pkg::SEL_VC_HDR,
			s_axi_rdata_o[15:0] == `CAP_ID_VC))
		else $error("capability identifier wrong");

	a_cap_version: assert property (
		p_field_fixed(serial_vc_pkg::SEL_VC_HDR,
			s_axi_rdata_o[19:16] == `CAP_VERSION))
		else $error("capability version wrong");

	a_ext_channel_count: assert property (
		p_field_fixed(serial_vc_pkg::SEL_VC_CP1,
			s_axi_rdata_o[2:0] == `EXT_CH_COUNT))
		else $error("extended channel count wrong");

	a_low_prio_count: assert property (
		p_field_fixed(serial_vc_pkg::SEL_VC_CP1,
			s_axi_rdata_o[6:4] == `LOW_PRIO_COUNT))
		else $error("low-priority channel count wrong");

	a_time_reference: assert property (
		p_field_fixed(serial_vc_pkg::SEL_VC_CP1,
			s_axi_rdata_o[9:8] == `ARB_TIME_REF))
		else $error("arbitration time reference wrong");

	a_entry_size: assert property (
		p_field_fixed(serial_vc_pkg::SEL_VC_CP1,
			s_axi_rdata_o[11:10] == `PORT_ARB_ENTRY_SIZE))
		else $error("port arbitration entry size wrong");

	a_arb_capability: assert property (
		p_field_fixed(serial_vc_pkg::SEL_VC_CP2,
			s_axi_rdata_o[7:0] == `CH_ARB_CAP))
		else $error("channel arbitration capability wrong");

	a_arb_table_offset: assert property (
		p_field_fixed(serial_vc_pkg::SEL_VC_CP2,
			s_axi_rdata_o[31:24] == `CH_ARB_TABLE_OFS))
		else $error("arbitration table offset wrong");

	a_reserved_zero: assert property (
		@(posedge clk_sys_i) disable iff (reset_i)
		s_axi_rvalid_o |->
			(rd_sel != serial_vc_pkg::SEL_VC_CP1 ||
			 (s_axi_rdata_o[31:12] == 20'h00000 && !s_axi_rdata_o[3]
			  && !s_axi_rdata_o[7]))
			&& (rd_sel != serial_vc_pkg::SEL_VC_CP2 ||
			 s_axi_rdata_o[23:8] == 16'h0000))
		else $error("reserved bits not zero");

endmodule : serial_vc_cap_regs

// file: test_serial_vc_cap_regs.sv
`timescale 1ns/1ns
`include "serial_vc_consts.svh"

module test_serial_vc_cap_regs;

	// ----------------------------------------------------------------
	// stimulus, observed signals, reference state
	// ----------------------------------------------------------------
	localparam int CYCLE_LIMIT = 8000;
	logic        clk_sys;
	logic        reset;
	logic        cold_reset;
	logic        ce;
	logic        fields_locked;
	logic [11:0] awaddr;
	logic        awvalid;
	logic        awready;
	logic [31:0] wdata;
	logic [3:0]  wstrb;
	logic        wvalid;
	logic        wready;
	logic [1:0]  bresp;
	logic        bvalid;
	logic        bready;
	logic [11:0] araddr;
	logic        arvalid;
	logic        arready;
	logic [31:0] rdata;
	logic [1:0]  rresp;
	logic        rvalid;
	logic        rready;
	logic [63:0] serial_value;
	logic [11:0] next_ptr;
	logic [31:0] m_lo;
	logic [31:0] m_hi;
	logic [11:0] m_nptr;
	logic [31:0] rd;
	int          mismatches;
	int          comparisons;
	int          cycles;
	logic [11:0] addr_table [7];

	serial_vc_cap_regs serial_vc_cap_regs_i
	(
		.clk_sys_i                 (clk_sys),
		.reset_i                   (reset),
		.cold_reset_i              (cold_reset),
		.ce_i                      (ce),
		.fields_locked_i           (fields_locked),
		.s_axi_awaddr_i            (awaddr),
		.s_axi_awvalid_i           (awvalid),
		.s_axi_awready_o           (awready),
		.s_axi_wdata_i             (wdata),
		.s_axi_wstrb_i             (wstrb),
		.s_axi_wvalid_i            (wvalid),
		.s_axi_wready_o            (wready),
		.s_axi_bresp_o             (bresp),
		.s_axi_bvalid_o            (bvalid),
		.s_axi_bready_i            (bready),
		.s_axi_araddr_i            (araddr),
		.s_axi_arvalid_i           (arvalid),
		.s_axi_arready_o           (arready),
		.s_axi_rdata_o             (rdata),
		.s_axi_rresp_o             (rresp),
		.s_axi_rvalid_o            (rvalid),
		.s_axi_rready_i            (rready),
		.serial_value_o            (serial_value),
		.next_capability_pointer_o (next_ptr)
	);

	// ----------------------------------------------------------------
	// reference model and comparison
	// ----------------------------------------------------------------
	function automatic logic [33:0] model_read(input logic [11:0] a);
		case ({a[11:2], 2'b00})
			`OFS_SERIAL_LOWER:    return {m_lo, 2'h0};
			`OFS_SERIAL_UPPER:    return {m_hi, 2'h0};
			`OFS_VC_CAP_HEADER:   return {m_nptr, 4'h1, 16'h0002, 2'h0};
			`OFS_PORT_VC_CAP_ONE: return {20'h0, 2'h2, 2'h0, 4'h0, 4'h1, 2'h0};
			`OFS_PORT_VC_CAP_TWO: return {32'h0, 2'h0};
			default:              return {32'h0, 2'h2};
		endcase
	endfunction : model_read

	task automatic model_write(input logic [11:0] a, input logic [31:0] d,
		input logic [3:0] s, output logic [1:0] r);
		logic [31:0] m;
		logic [31:0] w;
		m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
		w = ({m_nptr, 20'h0} & ~m) | (d & m);
		r = 2'h0;
		case ({a[11:2], 2'b00})
			`OFS_SERIAL_LOWER:  if (!fields_locked) m_lo = (m_lo & ~m) | (d & m);
			`OFS_SERIAL_UPPER:  if (!fields_locked) m_hi = (m_hi & ~m) | (d & m);
			`OFS_VC_CAP_HEADER: if (!fields_locked) m_nptr = w[31:20];
			`OFS_PORT_VC_CAP_ONE, `OFS_PORT_VC_CAP_TWO: r = 2'h0;
			default:            r = 2'h2;
		endcase
	endtask : model_write

	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// ----------------------------------------------------------------
	// bus master: every task is entered just after a rising edge
	// ----------------------------------------------------------------
	task automatic bus_write(input logic [11:0] a, input logic [31:0] d,
		input logic [3:0] s, output logic [1:0] r);
		logic aw_done;
		logic w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wstrb <= s;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(aw_done && w_done))
		begin
			@(posedge clk_sys);
			if (!aw_done && awready === 1'b1)
			begin
				aw_done = 1'b1;
				awvalid <= 1'b0;
			end
			if (!w_done && wready === 1'b1)
			begin
				w_done = 1'b1;
				wvalid <= 1'b0;
			end
		end
		do
			@(posedge clk_sys);
		while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
		// let an edge pass so the next call never re-raises in this step
		@(posedge clk_sys);
	endtask : bus_write

	task automatic read_and_check(input logic [11:0] a);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
			@(posedge clk_sys);
		while (arready !== 1'b1);
		arvalid <= 1'b0;
		do
			@(posedge clk_sys);
		while (rvalid !== 1'b1);
		rd = rdata;
		check({rdata, rresp}, model_read(a));
		rready <= 1'b0;
		@(posedge clk_sys);
	endtask : read_and_check

	task automatic write_and_check(input logic [11:0] a, input logic [31:0] d,
		input logic [3:0] s);
		logic [1:0] r_seen;
		logic [1:0] r_exp;
		bus_write(a, d, s, r_seen);
		model_write(a, d, s, r_exp);
		check(r_seen, r_exp);
		check(serial_value, {m_hi, m_lo});
		check(next_ptr, m_nptr);
	endtask : write_and_check

	task automatic report_and_stop();
		if (mismatches == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : report_and_stop

	// ----------------------------------------------------------------
	// clock and hang guard
	// ----------------------------------------------------------------
	initial
	begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end

	always @(posedge clk_sys)
	begin
		cycles <= cycles + 1;
		if (cycles == CYCLE_LIMIT)
		begin
			mismatches++;
			report_and_stop();
		end
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial
	begin
		{reset, cold_reset, fields_locked, ce} = 4'b1101;
		{awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
		{araddr, arvalid, rready} = '0;
		{m_lo, m_hi, m_nptr, mismatches, comparisons} = '0;
		addr_table = '{`OFS_SERIAL_LOWER, `OFS_SERIAL_UPPER, `OFS_VC_CAP_HEADER,
			`OFS_PORT_VC_CAP_ONE, `OFS_PORT_VC_CAP_TWO, 12'h20c, 12'h180};
		void'($urandom(32'hdf9327d6));
		repeat (2) @(posedge clk_sys);
		reset <= 1'b0;
		cold_reset <= 1'b0;
		@(posedge clk_sys);
		read_and_check(`OFS_SERIAL_UPPER);
		read_and_check(`OFS_SERIAL_LOWER);
		read_and_check(`OFS_VC_CAP_HEADER);
		check(rd[15:0], 16'h0002);
		check(rd[19:16], 4'h1);
		check(rd[31:20], 12'h000);
		read_and_check(`OFS_PORT_VC_CAP_ONE);
		check(rd[2:0], 3'h1);
		check(rd[6:4], 3'h0);
		check(rd[9:8], 2'h0);
		check(rd[11:10], 2'h2);
		check({rd[31:12], rd[7], rd[3]}, 22'h0);
		read_and_check(`OFS_PORT_VC_CAP_TWO);
		check(rd[7:0], 8'h00);
		check(rd[31:24], 8'h00);
		check(rd[23:8], 16'h0000);
		// fixed header bits must survive an all-ones write
		write_and_check(`OFS_VC_CAP_HEADER, 32'hffffffff, 4'hf);
		read_and_check(`OFS_VC_CAP_HEADER);
		write_and_check(`OFS_SERIAL_UPPER, $urandom(), 4'hf);
		write_and_check(`OFS_SERIAL_LOWER, $urandom(), 4'hf);
		fields_locked <= 1'b1;
		write_and_check(`OFS_SERIAL_UPPER, $urandom(), 4'hf);
		write_and_check(`OFS_VC_CAP_HEADER, 32'h0, 4'hf);
		// enable low over idle cycles: the stored words must not move
		ce <= 1'b0;
		repeat (3) @(posedge clk_sys);
		ce <= 1'b1;
		@(posedge clk_sys);
		check(serial_value, {m_hi, m_lo});
		check(next_ptr, m_nptr);
		// mixed traffic: random lock, strobes, addresses and low address bits
		repeat (80)
		begin
			fields_locked <= ($urandom_range(0, 3) == 0);
			if ($urandom_range(0, 1) != 0)
				write_and_check(addr_table[$urandom_range(0, 6)]
					| 12'($urandom_range(0, 3)), $urandom(),
					4'($urandom_range(0, 15)));
			else
				read_and_check(addr_table[$urandom_range(0, 6)]);
		end
		fields_locked <= 1'b0;
		// bus reset alone must leave the sticky words alone
		reset <= 1'b1;
		repeat (2) @(posedge clk_sys);
		reset <= 1'b0;
		@(posedge clk_sys);
		check(serial_value, {m_hi, m_lo});
		read_and_check(`OFS_SERIAL_UPPER);
		read_and_check(`OFS_VC_CAP_HEADER);
		cold_reset <= 1'b1;
		reset <= 1'b1;
		repeat (2) @(posedge clk_sys);
		{m_hi, m_lo, m_nptr} = '0;
		cold_reset <= 1'b0;
		reset <= 1'b0;
		@(posedge clk_sys);
		check(serial_value, 64'h0);
		check(next_ptr, 12'h000);
		read_and_check(`OFS_SERIAL_LOWER);
		report_and_stop();
	end

endmodule : test_serial_vc_cap_regs
